// ### core/hdp_device.sv
`timescale 1ns/1ps
`include "hdp_map.svh"
module hdp_device
  import hdp_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  hdp_if.dev                          bus,
  input  wire logic                   i_ring_n,
  input  wire logic                   i_engine_irq,
  input  wire logic                   i_eng_we,
  input  wire logic [`HDP_IDX_W-1:0]  i_eng_addr,
  input  wire logic [`HDP_DATA_W-1:0] i_eng_wdata,
  output logic      [`HDP_DATA_W-1:0] o_eng_rdata,
  output logic                        o_ring_detect,
  output logic                        o_divided_clock_out,
  output logic                        o_oscillator_output
);
  // All state of the device end, registered as one word, so that reset
  // and the clock edge treat every flip-flop alike.
  typedef struct packed {
    hdp_dev_state_t         st;        // Exchange phase.
    logic [2:0]             rd_s1;     // Read request, first stage.
    logic [2:0]             rd_s2;     // Read request, second stage.
    logic [2:0]             wr_s1;     // Write request, first stage.
    logic [2:0]             wr_s2;     // Write request, second stage.
    logic [`HDP_DATA_W-1:0] rdata;     // Byte shown on the host bus.
    logic                   oe;        // Data bus enable.
    logic                   ack;       // Acknowledge pull-down.
    logic                   irq;       // Interrupt pull-down.
    logic                   irq_ev;    // Last engine request level.
    logic                   ring_s1;   // Ring input, first stage.
    logic                   ring_s2;   // Ring input, second stage.
    logic                   div;       // Divided clock.
    logic [`HDP_DATA_W-1:0] eng_rdata; // Engine read byte.
    logic [`HDP_RAM_DEPTH*`HDP_DATA_W-1:0] ram; // Shared memory.
  } hdp_dev_reg_t;

  // The registered state and the next value that the logic builds.
  hdp_dev_reg_t q, d;

  // Maps a host address to the RAM index. The host address is one bit
  // wider than the memory needs; the top bit is dropped, so every byte
  // answers at two host addresses.
  function automatic logic [`HDP_IDX_W-1:0] hdp_idx(
    input logic [`HDP_ADDR_W-1:0] a);
    hdp_idx = a[`HDP_IDX_W-1:0];
  endfunction

  // Byte lane select into the flattened RAM vector.
  function automatic logic [`HDP_DATA_W-1:0] hdp_rd(
    input logic [`HDP_RAM_DEPTH*`HDP_DATA_W-1:0] m,
    input logic [`HDP_IDX_W-1:0]                 i);
    hdp_rd = m[i*`HDP_DATA_W +: `HDP_DATA_W];
  endfunction

  // Replaces one byte lane of the flattened RAM vector.
  function automatic logic [`HDP_RAM_DEPTH*`HDP_DATA_W-1:0] hdp_put(
    input logic [`HDP_RAM_DEPTH*`HDP_DATA_W-1:0] m,
    input logic [`HDP_IDX_W-1:0]                 i,
    input logic [`HDP_DATA_W-1:0]                b);
    hdp_put = m;
    hdp_put[i*`HDP_DATA_W +: `HDP_DATA_W] = b;
  endfunction

  // Raw requests from the pins, and the same after the synchroniser.
  logic sel_rd;
  logic sel_wr;
  logic rd_go;
  logic wr_go;

  // Decode the two bus styles into read and write requests. The style
  // pin is treated as a strap: changing it while a strobe is low can
  // turn one kind of request into the other.
  always_comb begin
    if (bus.bus_style_select == HDP_STYLE_SEP) begin
      sel_rd = ~bus.data_strobe_line_n;
      sel_wr = ~bus.direction_select_line;
    end else begin
      sel_rd = ~bus.data_strobe_line_n & bus.direction_select_line;
      sel_wr = ~bus.data_strobe_line_n & ~bus.direction_select_line;
    end
  end

  // Only the second synchroniser stage is looked at; the first may still
  // be settling from a pin that changed close to the clock edge.
  assign rd_go = q.rd_s2[0];
  assign wr_go = q.wr_s2[0];

  // Next-state logic. An exchange walks from idle to read or write and
  // then to done. The synchronised strobe is seen two edges after the
  // pin falls, read data is loaded one edge later and the acknowledge
  // one edge after that. Acknowledge and read data then stand until the
  // synchronised strobe drops, so a host that holds its strobe past this
  // latency always sees both; the price is four core cycles per access.
  always_comb begin
    d = q;

    // Chip select is folded in before the synchroniser so both cross
    // together; a select that rises mid-exchange ends it like a strobe.
    d.rd_s1 = {2'h0, sel_rd & ~bus.chip_select_line_n};
    d.wr_s1 = {2'h0, sel_wr & ~bus.chip_select_line_n};
    d.rd_s2 = q.rd_s1;
    d.wr_s2 = q.wr_s1;

    // The ring input crosses through two flip-flops like the strobes.
    d.ring_s1 = ~i_ring_n;
    d.ring_s2 = q.ring_s1;

    // Divide-by-two clock; the oscillator output pin shows its inverse.
    d.div = ~q.div;

    // Engine side port of the shared memory. It has no priority: a host
    // write to the same byte in the same cycle replaces the engine byte.
    d.eng_rdata = hdp_rd(q.ram, i_eng_addr);
    if (i_eng_we) begin
      d.ram = hdp_put(q.ram, i_eng_addr, i_eng_wdata);
    end

    // Interrupt is sticky; the engine sets and only the host clears. The
    // engine request is edge-detected, so a level left high sets it once,
    // and a set in the same cycle as a clear wins so no event is lost.
    d.irq_ev = i_engine_irq;
    if (i_engine_irq & ~q.irq_ev) begin
      d.irq = 1'b1;
    end else if (~bus.irq_clear_n) begin
      d.irq = 1'b0;
    end

    case (q.st)
      HDP_IDLE: begin
        // Read wins if both appear, which a style change or both separate strobes low at once can cause.
        if (rd_go) begin
          d.rdata = hdp_rd(q.ram, hdp_idx(bus.host_address_bus));
          d.oe = 1'b1;
          d.st = HDP_READ;
        end else if (wr_go) begin
          // Write data is taken in the next state, one edge later.
          d.st = HDP_WRITE;
        end
      end
      HDP_READ: begin
        // Data has stood on the pins a full cycle before the acknowledge,
        // which covers the data set-up that the host needs.
        d.ack = 1'b1;
        d.st = HDP_DONE;
      end
      HDP_WRITE: begin
        // Host write wins over an engine write to the same byte. Address
        // and data still stand, since the strobe is held low.
        d.ram = hdp_put(d.ram, hdp_idx(bus.host_address_bus),
                        bus.host_data_bus);
        d.ack = 1'b1;
        d.st = HDP_DONE;
      end
      HDP_DONE: begin
        // Hold ack and data until the strobe goes away. A host that never
        // lifts its strobe keeps the port busy; there is no timeout.
        if (~rd_go & ~wr_go) begin
          d.ack = 1'b0;
          d.oe = 1'b0;
          d.st = HDP_IDLE;
        end
      end
      // Unused codes fall back to idle.
      default: d.st = HDP_IDLE;
    endcase
  end

  // Asynchronous reset releases the open-drain lines and floats data.
  // The shared memory clears as well, so the engine starts from zeros.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Host pins come straight from flip-flops, so no glitch reaches the
  // open-drain lines or the data bus.
  assign bus.dev_data_out    = q.rdata;
  assign bus.dev_data_oe     = q.oe;
  assign bus.ack_pull        = q.ack;
  assign bus.irq_pull        = q.irq;

  // Engine and clock outputs, also registered.
  assign o_eng_rdata         = q.eng_rdata;
  assign o_ring_detect       = q.ring_s2;
  assign o_divided_clock_out = q.div;
  assign o_oscillator_output = ~q.div;
endmodule

// ### core/hdp_host.sv
`timescale 1ns/1ps
`include "hdp_map.svh"
// Host end: runs one exchange per request and waits for the acknowledge.
module hdp_host
  import hdp_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  hdp_if.host                         bus,
  input  wire logic                   i_style_sep,
  input  wire logic                   i_cs_off,
  input  wire logic                   i_req,
  input  wire logic                   i_write,
  input  wire logic [`HDP_ADDR_W-1:0] i_addr,
  input  wire logic [`HDP_DATA_W-1:0] i_wdata,
  input  wire logic                   i_irq_clear,
  output logic                        o_ready,
  output logic                        o_done,
  output logic      [`HDP_DATA_W-1:0] o_rdata,
  output logic                        o_irq
);
  typedef struct packed {
    hdp_host_state_t        st;
    logic                   wr;
    logic [`HDP_ADDR_W-1:0] addr;
    logic [`HDP_DATA_W-1:0] wdata;
    logic [`HDP_DATA_W-1:0] rdata;
    logic [`HDP_CNT_W-1:0]  cnt;
    logic                   done;
    logic                   nocs;
  } hdp_host_reg_t;

  hdp_host_reg_t q, d;
  logic          strobe;

  // Strobe is held for the minimum enable time and until acknowledge.
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      HDP_H_IDLE: begin
        if (i_req) begin
          d.wr = i_write;
          d.addr = i_addr;
          d.wdata = i_wdata;
          d.cnt = '0;
          d.nocs = i_cs_off;
          d.st = HDP_H_STROBE;
        end
      end
      HDP_H_STROBE: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == `HDP_CNT_W'(`HDP_STB_CYC - 1)) d.st = HDP_H_WAIT;
      end
      HDP_H_WAIT: begin
        // Without chip select no acknowledge can come, so give up then.
        if (!bus.transfer_ack_line_n || q.nocs) begin
          d.rdata = bus.host_data_bus;
          d.st = HDP_H_RELEASE;
        end
      end
      HDP_H_RELEASE: begin
        d.cnt = '0;
        d.done = 1'b1;
        d.st = HDP_H_GAP;
      end
      HDP_H_GAP: begin
        // Inactive gap between strobes so the device sees the edge.
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == `HDP_CNT_W'(`HDP_GAP_CYC - 1)) d.st = HDP_H_IDLE;
      end
      default: d.st = HDP_H_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign strobe = (q.st == HDP_H_STROBE) || (q.st == HDP_H_WAIT);

  // Pin encoding for each style; chip select only during the strobe.
  always_comb begin
    if (i_style_sep) begin
      bus.data_strobe_line_n    = ~(strobe & ~q.wr);
      bus.direction_select_line = ~(strobe & q.wr);
    end else begin
      bus.data_strobe_line_n    = ~strobe;
      bus.direction_select_line = ~q.wr;
    end
  end

  assign bus.bus_style_select   = i_style_sep ? HDP_STYLE_SEP : HDP_STYLE_DIR;
  assign bus.chip_select_line_n = ~(strobe & ~q.nocs);
  assign bus.host_address_bus   = q.addr;
  assign bus.host_data_out      = q.wdata;
  assign bus.host_data_oe       = strobe & q.wr;
  assign bus.irq_clear_n        = ~i_irq_clear;
  assign o_ready                = (q.st == HDP_H_IDLE);
  assign o_done                 = q.done;
  assign o_rdata                = q.rdata;
  assign o_irq                  = ~bus.host_irq_line_n;
endmodule

// ### core/hdp_if.sv
`timescale 1ns/1ps
`include "hdp_map.svh"
// Host port wires; open-drain and three-state levels are resolved here.
interface hdp_if;
  logic [`HDP_DATA_W-1:0] dev_data_out;
  logic                   dev_data_oe;
  logic [`HDP_DATA_W-1:0] host_data_out;
  logic                   host_data_oe;
  logic [`HDP_ADDR_W-1:0] host_address_bus;
  logic                   data_strobe_line_n;
  logic                   direction_select_line;
  logic                   chip_select_line_n;
  logic                   ack_pull;
  logic                   irq_pull;
  logic                   irq_clear_n;
  logic                   bus_style_select;
  logic [`HDP_DATA_W-1:0] host_data_bus;
  logic                   transfer_ack_line_n;
  logic                   host_irq_line_n;

  // Data bus: whichever end enables drives it; idle reads as all ones.
  assign host_data_bus = dev_data_oe ? dev_data_out :
                         host_data_oe ? host_data_out :
                         {`HDP_DATA_W{1'b1}};
  // Open-drain lines float high through the pull-up.
  assign transfer_ack_line_n = ~ack_pull;
  assign host_irq_line_n     = ~irq_pull;

  modport dev (
    input  host_data_bus, host_address_bus, data_strobe_line_n,
    input  direction_select_line, chip_select_line_n, irq_clear_n,
    input  bus_style_select,
    output dev_data_out, dev_data_oe, ack_pull, irq_pull
  );
  modport host (
    input  host_data_bus, transfer_ack_line_n, host_irq_line_n,
    output host_data_out, host_data_oe, host_address_bus,
    output data_strobe_line_n, direction_select_line, chip_select_line_n,
    output irq_clear_n, bus_style_select
  );
endinterface

// ### core/hdp_map.svh
`ifndef HDP_MAP_SVH
`define HDP_MAP_SVH
// Shared memory geometry and bus widths.
`define HDP_DATA_W     8
`define HDP_ADDR_W     7
`define HDP_RAM_DEPTH  64
`define HDP_IDX_W      6
// Strobe and gap widths the host holds, in ns, rounded up to core cycles.
`define HDP_STB_NS     45
`define HDP_GAP_NS     70
`define HDP_CLK_NS     5
`define HDP_STB_CYC    ((`HDP_STB_NS + `HDP_CLK_NS - 1) / `HDP_CLK_NS)
`define HDP_GAP_CYC    ((`HDP_GAP_NS + `HDP_CLK_NS - 1) / `HDP_CLK_NS)
`define HDP_CNT_W      5
// Oscillator nominal frequency in kHz; the bench does not use it.
`define HDP_OSC_KHZ    29491
`endif

// ### core/hdp_pkg.sv
package hdp_pkg;
  // Bus style: strobe plus direction, or separate read and write strobes.
  typedef enum logic {
    HDP_STYLE_DIR,
    HDP_STYLE_SEP
  } hdp_style_t;
  typedef enum logic [1:0] {
    HDP_IDLE,
    HDP_READ,
    HDP_WRITE,
    HDP_DONE
  } hdp_dev_state_t;
  typedef enum logic [2:0] {
    HDP_H_IDLE,
    HDP_H_STROBE,
    HDP_H_WAIT,
    HDP_H_RELEASE,
    HDP_H_GAP
  } hdp_host_state_t;
endpackage

// ### sim/hdp_port_asserts.sv
`timescale 1ns/1ps
// Watches the shared host wires that join the two ends.
module hdp_port_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic dev_data_oe,
  input wire logic ack_pull,
  input wire logic irq_pull,
  input wire logic irq_clear_n,
  input wire logic data_strobe_line_n,
  input wire logic direction_select_line,
  input wire logic chip_select_line_n,
  input wire logic bus_style_select
);
  logic stb_on;
  // A separate-strobe write strobes on the direction line instead.
  assign stb_on = !chip_select_line_n && (!data_strobe_line_n ||
                  (bus_style_select && !direction_select_line));
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_oe_read_cause: assert property (
    $rose(dev_data_oe) |-> $past(stb_on, 2) &&
    $past(direction_select_line, 2))
    else $error("data driven without a read strobe");
  a_ack_has_cause: assert property (
    $rose(ack_pull) |-> $past(stb_on, 3))
    else $error("acknowledge without a strobe");
  a_ack_read_drives: assert property (
    $rose(ack_pull) && $past(direction_select_line, 3) |-> dev_data_oe)
    else $error("read acknowledged without data");
  a_write_no_drive: assert property (
    $rose(ack_pull) && !$past(direction_select_line, 3) |-> !dev_data_oe)
    else $error("data driven during a write");
  a_idle_released: assert property (
    !stb_on [*6] |-> !ack_pull && !dev_data_oe)
    else $error("ack or data held after the strobe");
  a_cs_high_quiet: assert property (
    chip_select_line_n [*6] |-> !ack_pull && !dev_data_oe)
    else $error("response while not selected");
  a_irq_holds: assert property (
    irq_pull && irq_clear_n |=> irq_pull)
    else $error("interrupt withdrawn without host action");
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_rst_n && !$past(i_rst_n) |-> !ack_pull && !irq_pull && !dev_data_oe)
    else $error("outputs active in reset");
endmodule

// ### sim/host_dual_port_ram_interface_tb.sv
`timescale 1ns/1ps
`include "hdp_map.svh"
// Joins both ends and runs directed host and engine scenarios.
module host_dual_port_ram_interface_tb;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       style_sep = 1'b0;
  logic       req = 1'b0;
  logic       wr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic       irq_clear = 1'b0;
  logic       cs_off = 1'b0;
  logic       ring_n = 1'b1;
  logic       eng_irq = 1'b0;
  logic       eng_we = 1'b0;
  logic [5:0] eng_addr = 6'h00;
  logic [7:0] eng_wdata = 8'h00;
  logic       ready, done, irq, ring_det, div_clk, osc_out, prev;
  logic [7:0] rdata, eng_rdata;
  int         fails = 0;
  int         checks_done = 0;

  hdp_if bus_if ();
  hdp_device i_hdp_device (.i_core_clk(core_clk), .i_rst_n(rst_n),
    .bus(bus_if), .i_ring_n(ring_n), .i_engine_irq(eng_irq),
    .i_eng_we(eng_we), .i_eng_addr(eng_addr), .i_eng_wdata(eng_wdata),
    .o_eng_rdata(eng_rdata), .o_ring_detect(ring_det),
    .o_divided_clock_out(div_clk), .o_oscillator_output(osc_out));
  hdp_host i_hdp_host (.i_core_clk(core_clk), .i_rst_n(rst_n),
    .bus(bus_if), .i_style_sep(style_sep), .i_cs_off(cs_off),
    .i_req(req), .i_write(wr),
    .i_addr(addr), .i_wdata(wdata), .i_irq_clear(irq_clear),
    .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_irq(irq));
  hdp_port_asserts i_hdp_port_asserts (.i_core_clk(core_clk),
    .i_rst_n(rst_n), .dev_data_oe(bus_if.dev_data_oe),
    .ack_pull(bus_if.ack_pull), .irq_pull(bus_if.irq_pull),
    .irq_clear_n(bus_if.irq_clear_n),
    .data_strobe_line_n(bus_if.data_strobe_line_n),
    .direction_select_line(bus_if.direction_select_line),
    .chip_select_line_n(bus_if.chip_select_line_n),
    .bus_style_select(bus_if.bus_style_select));

  // The 200 MHz core clock; the oscillator frequency is not modelled, the
  // bench only supplies a steady clock in its place.
  always #2.5 core_clk = ~core_clk;

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One host exchange; the done pulse is looked at in its own cycle.
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
    repeat (100) if (ready !== 1'b1) @(negedge core_clk);
    check("ready", 8'h01, {7'h00, ready});
    wr = w;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    repeat (100) if (done !== 1'b1) @(negedge core_clk);
    check("done", 8'h01, {7'h00, done});
  endtask

  task automatic eng_put(input logic [5:0] a, input logic [7:0] d);
    eng_addr = a;
    eng_wdata = d;
    eng_we = 1'b1;
    @(negedge core_clk);
    eng_we = 1'b0;
  endtask

  task automatic t_dir();
    style_sep = 1'b0;
    xfer(1'b1, 7'h03, 8'hA5);
    xfer(1'b0, 7'h43, 8'h00);
    check("alias read", 8'hA5, rdata);
    eng_addr = 6'h03;
    @(negedge core_clk);
    check("engine read", 8'hA5, eng_rdata);
    $display("test direction style done");
  endtask

  // A strobe without chip select must leave the shared memory alone.
  task automatic t_cs();
    xfer(1'b1, 7'h05, 8'h11);
    cs_off = 1'b1;
    xfer(1'b1, 7'h05, 8'h77);
    cs_off = 1'b0;
    xfer(1'b0, 7'h05, 8'h00);
    check("unselected write", 8'h11, rdata);
    $display("test chip select done");
  endtask

  task automatic t_sep();
    style_sep = 1'b1;
    xfer(1'b1, 7'h3F, 8'h5A);
    xfer(1'b0, 7'h3F, 8'h00);
    check("sep read", 8'h5A, rdata);
    eng_put(6'h00, 8'hC3);
    xfer(1'b0, 7'h00, 8'h00);
    check("engine byte", 8'hC3, rdata);
    style_sep = 1'b0;
    $display("test separate style done");
  endtask

  // The request must outlive a long wait and drop only on a clear.
  task automatic t_irq();
    eng_irq = 1'b1;
    @(negedge core_clk);
    eng_irq = 1'b0;
    repeat (40) @(negedge core_clk);
    check("irq held", 8'h01, {7'h00, irq});
    irq_clear = 1'b1;
    repeat (10) @(negedge core_clk);
    irq_clear = 1'b0;
    check("irq cleared", 8'h00, {7'h00, irq});
    $display("test interrupt done");
  endtask

  task automatic t_misc();
    ring_n = 1'b0;
    repeat (4) @(negedge core_clk);
    check("ring", 8'h01, {7'h00, ring_det});
    ring_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("no ring", 8'h00, {7'h00, ring_det});
    prev = div_clk;
    @(negedge core_clk);
    check("clk div", {7'h00, ~prev}, {7'h00, div_clk});
    check("osc out", {7'h00, ~div_clk}, {7'h00, osc_out});
    $display("test ring and clock done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_dir();
    t_cs();
    t_sep();
    t_irq();
    t_misc();
    final_report();
  end

  // The tests need well under 1000 cycles; allow ten times that.
  initial begin
    #50000;
    fails++;
    final_report();
  end
endmodule
